// file: hw/atf_pkg.sv
// constants and state type of the serial transmit framer
// assumes a 100 MHz clk and 32-bit APB register access
package atf_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ATF_OFS_STATUS = 8'h00;
  localparam logic [7:0] ATF_OFS_DATA   = 8'h04;
  localparam logic [7:0] ATF_OFS_CTL1   = 8'h08;
  localparam logic [7:0] ATF_OFS_CTL2   = 8'h0C;
  localparam logic [7:0] ATF_OFS_RATE   = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ATF_ST_TX_BUFFER_EMPTY_FLAG   = 0;
  localparam int ATF_ST_TC     = 1;
  localparam int ATF_C1_WORD9  = 0;
  localparam int ATF_C1_NINTH  = 1;
  localparam int ATF_C1_PAREN  = 2;
  localparam int ATF_C1_PARODD = 3;
  localparam int ATF_C2_TE     = 0;
  localparam int ATF_C2_RE     = 1;
  localparam int ATF_C2_SBK    = 2;
  localparam int ATF_C2_TIE    = 3;
  localparam int ATF_C2_TX_COMPLETE_IRQ_EN   = 4;

  // ----------------------------------------------------------------
  // timing and framing
  // ----------------------------------------------------------------
  localparam int ATF_CLK_NS      = 10;
  localparam int ATF_BIT_TIME_NS = 2000;
  localparam int ATF_BIT_CYC     = ATF_BIT_TIME_NS / ATF_CLK_NS;
  localparam logic [15:0] ATF_RATE_RST = 16'(ATF_BIT_CYC - 1);
  localparam logic [3:0]  ATF_IDLE8    = 4'hA;
  localparam logic [3:0]  ATF_IDLE9    = 4'hB;

  typedef enum logic [4:0] {
    ATF_IDLE   = 5'h01,
    ATF_PRE    = 5'h02,
    ATF_DATA   = 5'h04,
    ATF_BRK    = 5'h08,
    ATF_BRKEND = 5'h10
  } atf_state_t;

endpackage

// file: hw/atf_tx_framer.sv
// transmit framer of an asynchronous NRZ serial unit with APB registers
// assumes an APB master on clk; serial_out drives a pin muxed with a port
//
// Notes on behaviour
// - idle enabled line stays high; disabled transmitter releases the pin
// - character is start, 8 or 9 data bits LSB first, stop
// - start bit driven low, stop bit driven high
// - idle character is 10 high bits, or 11 with 9-bit words
// - break is a run of low bits then one high bit
// - word-length bit clear gives 8 data bits, set gives 9
// - in 9-bit mode ninth-bit control is sent as MSB
// - writes pass one holding buffer into shift register, LSB first
// - enabling transmitter first sends 10 or 11 ones
// - buffer-empty clears only by status read then data write
// - buffer-empty sets when holding buffer moves into shift register
// - empty interrupt when flag, enable set and cpu mask clear
// - write during transmission waits in holding buffer until character ends
// - write while idle loads shift register, starts, sets empty flag
// - complete flag set after stop bit; interrupt if enabled, unmasked
// - transmit and receive rates programmed separately, 500K baud out of reset
// - parity bit appended when parity control is on
// - transmitter and receiver have separate enable bits
// - complete flag cleared by same status-read then data-write sequence
// - break repeats while send-break set; one high bit after last
// - re-enable mid-word sends fresh preamble after word; holding data lost
`timescale 1ns/1ns

module atf_tx_framer import atf_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu interrupt mask bits
  input  wire logic [1:0]  cpu_irq_mask,
  // serial pin
  output logic             serial_out,
  output logic             serial_out_en,
  // receiver side controls
  output logic             rx_enable,
  output logic      [15:0] rx_bit_period,
  // interrupt requests
  output logic             tx_empty_irq,
  output logic             tx_complete_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    atf_state_t  st;
    logic        line;
    logic [11:0] sr;
    logic [3:0]  cnt;
    logic [15:0] tcnt;
    logic        te_q;
    logic        pre_pend;
    logic        sh_full;
    logic [7:0]  sh_data;
    logic        hold_full;
    logic [7:0]  hold;
    logic        tx_buffer_empty_flag;
    logic        tc;
    logic        armed;
    logic [3:0]  ctl1;
    logic [4:0]  ctl2;
    logic [31:0] rate;
    logic [31:0] prdata;
  } atf_regs_t;

  atf_regs_t   r_ff;
  atf_regs_t   nxt_r;
  logic        tick;
  logic        acc;
  logic        setup;
  logic        mapped;
  logic        wr_data;
  logic        busy;
  logic [31:0] rd_mux;

  assign acc     = psel & penable;
  assign setup   = psel & ~penable;
  assign mapped  = (paddr == ATF_OFS_STATUS) || (paddr == ATF_OFS_DATA) ||
                   (paddr == ATF_OFS_CTL1) || (paddr == ATF_OFS_CTL2) ||
                   (paddr == ATF_OFS_RATE);
  assign wr_data = acc & pwrite & (paddr == ATF_OFS_DATA);
  assign tick    = (r_ff.tcnt == 16'h0000);
  // anything queued or on the line means a write must wait its turn
  assign busy    = (r_ff.st != ATF_IDLE) | r_ff.sh_full | r_ff.hold_full |
                   r_ff.pre_pend | r_ff.ctl2[ATF_C2_SBK];

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ATF_OFS_STATUS: begin
        rd_mux[ATF_ST_TX_BUFFER_EMPTY_FLAG] = r_ff.tx_buffer_empty_flag;
        rd_mux[ATF_ST_TC]   = r_ff.tc;
      end
      ATF_OFS_CTL1: rd_mux[3:0] = r_ff.ctl1;
      ATF_OFS_CTL2: rd_mux[4:0] = r_ff.ctl2;
      ATF_OFS_RATE: rd_mux      = r_ff.rate;
      default:      rd_mux      = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [11:0] body;
    logic [8:0]  word;
    logic        par;
    logic [3:0]  plen;
    body = 12'hFFF;
    word = 9'h000;
    par  = 1'b0;
    plen = 4'h0;
    nxt_r = r_ff;

    // bit-period tick; transmit period independent of receive period
    nxt_r.tcnt = tick ? r_ff.rate[15:0] : r_ff.tcnt - 16'h0001;
    nxt_r.te_q = r_ff.ctl2[ATF_C2_TE];

    // bus access
    if (setup) begin
      nxt_r.prdata = rd_mux;
    end
    if (acc & ~pwrite & (paddr == ATF_OFS_STATUS)) begin
      nxt_r.armed = 1'b1;
    end
    if (acc & pwrite & (paddr == ATF_OFS_CTL1)) begin
      nxt_r.ctl1 = pwdata[3:0];
    end
    if (acc & pwrite & (paddr == ATF_OFS_CTL2)) begin
      nxt_r.ctl2 = pwdata[4:0];
    end
    if (acc & pwrite & (paddr == ATF_OFS_RATE)) begin
      nxt_r.rate = pwdata;
    end
    if (wr_data) begin
      if (r_ff.armed) begin
        nxt_r.tx_buffer_empty_flag  = 1'b0;
        nxt_r.tc    = 1'b0;
        nxt_r.armed = 1'b0;
      end
      if (!busy) begin
        nxt_r.sh_full = 1'b1;
        nxt_r.sh_data = pwdata[7:0];
        nxt_r.tx_buffer_empty_flag    = 1'b1;
      end else begin
        nxt_r.hold      = pwdata[7:0];
        nxt_r.hold_full = 1'b1;
      end
    end

    // enable edge: queue preamble, drop any held byte
    if (r_ff.ctl2[ATF_C2_TE] & ~r_ff.te_q) begin
      nxt_r.pre_pend  = 1'b1;
      nxt_r.hold_full = 1'b0;
      nxt_r.tx_buffer_empty_flag      = 1'b1;
    end

    plen = r_ff.ctl1[ATF_C1_WORD9] ? ATF_IDLE9 : ATF_IDLE8;

    // line sequencer
    if (tick) begin
      if ((r_ff.st != ATF_IDLE) && (r_ff.cnt != 4'h0)) begin
        nxt_r.line = r_ff.sr[0];
        nxt_r.sr   = {r_ff.sr[11], r_ff.sr[11:1]};
        nxt_r.cnt  = r_ff.cnt - 4'h1;
      end else begin
        if (r_ff.st == ATF_DATA) begin
          nxt_r.tc = 1'b1;
        end
        if ((r_ff.st == ATF_BRK) && !r_ff.ctl2[ATF_C2_SBK]) begin
          nxt_r.st   = ATF_BRKEND;
          nxt_r.line = 1'b1;
          nxt_r.cnt  = 4'h0;
        end else if (!r_ff.ctl2[ATF_C2_TE]) begin
          nxt_r.st   = ATF_IDLE;
          nxt_r.line = 1'b1;
        end else if (r_ff.pre_pend) begin
          nxt_r.st       = ATF_PRE;
          nxt_r.line     = 1'b1;
          nxt_r.sr       = 12'hFFF;
          nxt_r.cnt      = plen - 4'h1;
          nxt_r.pre_pend = 1'b0;
        end else if (r_ff.ctl2[ATF_C2_SBK]) begin
          nxt_r.st   = ATF_BRK;
          nxt_r.line = 1'b0;
          nxt_r.sr   = 12'h000;
          nxt_r.cnt  = plen - 4'h1;
        end else if (r_ff.sh_full || r_ff.hold_full) begin
          // shift stage first; a held byte waits for the end of the character
          word = {r_ff.ctl1[ATF_C1_NINTH] & r_ff.ctl1[ATF_C1_WORD9],
                  r_ff.sh_full ? r_ff.sh_data : r_ff.hold};
          par  = (^word) ^ r_ff.ctl1[ATF_C1_PARODD];
          body[7:0] = word[7:0];
          if (r_ff.ctl1[ATF_C1_WORD9]) begin
            body[8] = word[8];
          end
          if (r_ff.ctl1[ATF_C1_PAREN]) begin
            body[r_ff.ctl1[ATF_C1_WORD9] ? 9 : 8] = par;
          end
          // start goes out now; stop is the first of the trailing ones
          nxt_r.st      = ATF_DATA;
          nxt_r.line    = 1'b0;
          nxt_r.sr      = body;
          nxt_r.cnt     = 4'h9 + {3'h0, r_ff.ctl1[ATF_C1_WORD9]} +
                          {3'h0, r_ff.ctl1[ATF_C1_PAREN]};
          nxt_r.sh_full = 1'b0;
          if (!r_ff.sh_full) begin
            // a byte written in this very cycle takes the freed slot
            nxt_r.hold_full = nxt_r.hold_full & wr_data;
            nxt_r.tx_buffer_empty_flag      = nxt_r.tx_buffer_empty_flag | ~wr_data;
          end
        end else begin
          nxt_r.st   = ATF_IDLE;
          nxt_r.line = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '{st: ATF_IDLE, line: 1'b1, sr: 12'hFFF, cnt: 4'h0,
                tcnt: 16'h0000, te_q: 1'b0, pre_pend: 1'b0,
                sh_full: 1'b0, sh_data: 8'h00, hold_full: 1'b0,
                hold: 8'h00, tx_buffer_empty_flag: 1'b1, tc: 1'b1, armed: 1'b0,
                ctl1: 4'h0, ctl2: 5'h00,
                rate: {ATF_RATE_RST, ATF_RATE_RST}, prdata: 32'h0000_0000};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata          = r_ff.prdata;
  assign pready          = 1'b1;
  assign pslverr         = acc & ~mapped;
  assign serial_out      = r_ff.line;
  assign serial_out_en   = r_ff.ctl2[ATF_C2_TE];
  assign rx_enable       = r_ff.ctl2[ATF_C2_RE];
  assign rx_bit_period   = r_ff.rate[31:16];
  assign tx_empty_irq    = r_ff.tx_buffer_empty_flag & r_ff.ctl2[ATF_C2_TIE] &
                           (cpu_irq_mask == 2'h0);
  assign tx_complete_irq = r_ff.tc & r_ff.ctl2[ATF_C2_TX_COMPLETE_IRQ_EN] &
                           (cpu_irq_mask == 2'h0);

  // ----------------------------------------------------------------
  // check helpers
  // ----------------------------------------------------------------
  // bit counters kept apart from the shift counter, so a wrong load
  // of cnt cannot hide behind itself
  logic [3:0] pre_ticks_ff;
  logic [3:0] nxt_pre_ticks;
  logic [3:0] frame_ticks_ff;
  logic [3:0] nxt_frame_ticks;
  logic [3:0] pre_last;
  logic [3:0] frame_last;

  assign pre_last   = (r_ff.ctl1[ATF_C1_WORD9] ? ATF_IDLE9 : ATF_IDLE8) - 4'h1;
  assign frame_last = 4'h9 + {3'h0, r_ff.ctl1[ATF_C1_WORD9]} +
                      {3'h0, r_ff.ctl1[ATF_C1_PAREN]};

  always_comb begin
    nxt_pre_ticks   = pre_ticks_ff;
    nxt_frame_ticks = frame_ticks_ff;
    if (r_ff.st != ATF_PRE) begin
      nxt_pre_ticks = 4'h0;
    end else if (tick) begin
      nxt_pre_ticks = pre_ticks_ff + 4'h1;
    end
    if (r_ff.st != ATF_DATA) begin
      nxt_frame_ticks = 4'h0;
    end else if (tick) begin
      nxt_frame_ticks = (r_ff.cnt == 4'h0) ? 4'h0 : frame_ticks_ff + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ticks_ff   <= 4'h0;
      frame_ticks_ff <= 4'h0;
    end else begin
      pre_ticks_ff   <= nxt_pre_ticks;
      frame_ticks_ff <= nxt_frame_ticks;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  idle_line_high_a: assert property (r_ff.st == ATF_IDLE |-> serial_out)
    else $error("line not high while idle");
  pin_release_a: assert property ($fell(r_ff.ctl2[ATF_C2_TE]) |-> !serial_out_en)
    else $error("pin still driven after disable");
  start_low_a: assert property ((r_ff.st == ATF_DATA) && ($past(r_ff.st) != ATF_DATA)
    |-> !serial_out && $past(tick))
    else $error("start bit not low");
  stop_high_a: assert property ((r_ff.st == ATF_DATA) && (r_ff.cnt == 4'h0)
    |-> serial_out)
    else $error("stop bit not high");
  tick_edge_a: assert property ($changed(serial_out) |-> $past(tick))
    else $error("line moved between ticks");
  tc_after_stop_a: assert property (tick && (r_ff.st == ATF_DATA) && (r_ff.cnt == 4'h0)
    |=> r_ff.tc)
    else $error("complete flag not set after stop");
  tx_buffer_empty_flag_clear_a: assert property ($fell(r_ff.tx_buffer_empty_flag) |-> $past(wr_data && r_ff.armed))
    else $error("empty flag cleared without sequence");
  direct_load_a: assert property (wr_data && !busy |=> r_ff.tx_buffer_empty_flag && r_ff.sh_full)
    else $error("idle write did not load shift stage");
  preamble_len_a: assert property ((r_ff.st == ATF_PRE) && ($past(r_ff.st) != ATF_PRE)
    |-> r_ff.cnt == (r_ff.ctl1[ATF_C1_WORD9] ? 4'hA : 4'h9))
    else $error("preamble length wrong");
  break_tail_a: assert property ((r_ff.st == ATF_BRKEND) |-> serial_out)
    else $error("no high bit after break");
  irq_mask_a: assert property (cpu_irq_mask != 2'h0 |-> !tx_empty_irq && !tx_complete_irq)
    else $error("interrupt raised while masked");
  preamble_bits_a: assert property ((r_ff.st == ATF_PRE) && tick && (r_ff.cnt == 4'h0)
    |-> pre_ticks_ff == pre_last)
    else $error("preamble bit count wrong");
  frame_bits_a: assert property ((r_ff.st == ATF_DATA) && tick && (r_ff.cnt == 4'h0)
    |-> frame_ticks_ff == frame_last)
    else $error("frame bit count wrong");
  break_low_a: assert property ((r_ff.st == ATF_BRK) && ($past(r_ff.st) != ATF_BRK)
    |-> !serial_out && (r_ff.cnt == pre_last))
    else $error("break not low for a character");
  break_repeat_a: assert property (tick && (r_ff.st == ATF_BRK) && (r_ff.cnt == 4'h0) &&
    r_ff.ctl2[ATF_C2_SBK] && r_ff.ctl2[ATF_C2_TE] && !r_ff.pre_pend
    |=> (r_ff.st == ATF_BRK) && !serial_out)
    else $error("break not repeated");
  tick_period_a: assert property (tick |=> r_ff.tcnt == $past(r_ff.rate[15:0]))
    else $error("bit period not reloaded");
  tc_clear_a: assert property ($fell(r_ff.tc) |-> $past(wr_data && r_ff.armed))
    else $error("complete flag cleared without sequence");
  hold_drop_a: assert property (r_ff.ctl2[ATF_C2_TE] && !r_ff.te_q |=> !r_ff.hold_full)
    else $error("held byte kept over re-enable");
  tx_buffer_empty_flag_set_a: assert property (tick && (r_ff.st == ATF_DATA) && (r_ff.cnt == 4'h0) &&
    r_ff.hold_full && !r_ff.sh_full && r_ff.ctl2[ATF_C2_TE] && !r_ff.pre_pend &&
    !r_ff.ctl2[ATF_C2_SBK] |=> r_ff.tx_buffer_empty_flag || $past(wr_data))
    else $error("empty flag not set on buffer move");

  frame_sent_c: cover property ((r_ff.st == ATF_DATA) ##1 (r_ff.st == ATF_IDLE));
  held_byte_c: cover property (r_ff.hold_full ##1 !r_ff.hold_full && r_ff.sh_full);
  break_end_c: cover property ((r_ff.st == ATF_BRK) ##1 (r_ff.st == ATF_BRKEND));
  parity_frame_c: cover property ((r_ff.st == ATF_DATA) && r_ff.ctl1[ATF_C1_PAREN]);
  preamble_c: cover property ((r_ff.st == ATF_PRE) ##1 (r_ff.st == ATF_DATA));

endmodule // atf_tx_framer

// file: sim/atf_line_rx.sv
// far-end receiver model watching the serial pin of the framer
// assumes bit period of BIT clk cycles and an idle-high line
`timescale 1ns/1ns

module atf_line_rx #(
  parameter int BIT = 4
) (
  // clock
  input  wire logic       clk,
  // serial pin
  input  wire logic       line,
  input  wire logic       line_en,
  // word length select
  input  wire logic       word9,
  // decoded character
  output logic      [8:0] rx_word,
  output logic            rx_stop,
  output int              rx_cnt
);
  logic prev = 1'b1;
  int   n;

  // ----------------------------------------------------------------
  // decoder
  // ----------------------------------------------------------------
  // samples mid-bit, so tick phase of the framer does not matter
  initial begin
    rx_word = '0;
    rx_stop = 1'b0;
    rx_cnt  = 0;
    forever begin
      @(posedge clk);
      if (line_en && prev && !line) begin
        repeat (BIT / 2) @(posedge clk);
        n = word9 ? 9 : 8;
        rx_word = '0;
        for (int i = 0; i < n; i++) begin
          repeat (BIT) @(posedge clk);
          rx_word[i] = line;
        end
        repeat (BIT) @(posedge clk);
        rx_stop = line;
        rx_cnt++;
      end
      prev = line;
    end
  end
endmodule // atf_line_rx

// file: sim/testbench.sv
// self-checking bench of the transmit framer over APB
// assumes rate register shortened to 4 clk per bit
`timescale 1ns/1ns

module testbench import atf_pkg::*;;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, w9;
  logic serial_out, serial_out_en, rx_enable, tx_empty_irq, tx_complete_irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] rx_bit_period;
  logic [1:0]  cpu_irq_mask;
  logic [8:0]  rx_word;
  logic        rx_stop;
  int          rx_cnt, cyc, t0, mismatches, num_checks;

  atf_tx_framer uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask),
    .serial_out(serial_out), .serial_out_en(serial_out_en), .rx_enable(rx_enable),
    .rx_bit_period(rx_bit_period), .tx_empty_irq(tx_empty_irq),
    .tx_complete_irq(tx_complete_irq));
  atf_line_rx #(.BIT(4)) peer (.clk(clk), .line(serial_out), .line_en(serial_out_en),
    .word9(w9), .rx_word(rx_word), .rx_stop(rx_stop), .rx_cnt(rx_cnt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int g;
    g = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      g++;
    end while (pready !== 1'b1 && g < 50);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", e, q);
  endtask

  task wait_rx(input int n);
    int g;
    g = 0;
    while (rx_cnt < n && g < 400) begin
      @(posedge clk);
      g++;
    end
    chk("frame count", n, rx_cnt);
  endtask

  // ----------------------------------------------------------------
  // clock, reset, timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, w9} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_irq_mask = 2'h3;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(ATF_OFS_STATUS, 32'h3);
    chk("pin enable", 1'b0, serial_out_en);
    rd(ATF_OFS_RATE, 32'h00C700C7);
    apb(1'b1, ATF_OFS_RATE, 32'h00030003);
    chk("rx period", 16'h0003, rx_bit_period);
    repeat (250) @(posedge clk);
    apb(1'b1, ATF_OFS_CTL2, 32'h3);
    t0 = cyc;
    chk("rx enable", 1'b1, rx_enable);
    chk("pin enable", 1'b1, serial_out_en);
    rd(ATF_OFS_STATUS, 32'h3);
    apb(1'b1, ATF_OFS_DATA, 32'hA5);
    rd(ATF_OFS_STATUS, 32'h0);
    while (serial_out !== 1'b0 && cyc - t0 < 200) @(posedge clk);
    chk("preamble", 1'b1, (cyc - t0 >= 40) && (cyc - t0 <= 50));
    wait_rx(1);
    chk("word", 9'h0A5, rx_word);
    chk("stop", 1'b1, rx_stop);
    repeat (8) @(posedge clk);
    rd(ATF_OFS_STATUS, 32'h3);
    apb(1'b1, ATF_OFS_DATA, 32'h3C);
    rd(ATF_OFS_STATUS, 32'h1);
    apb(1'b1, ATF_OFS_DATA, 32'hC3);
    rd(ATF_OFS_STATUS, 32'h0);
    wait_rx(2);
    chk("word", 9'h03C, rx_word);
    wait_rx(3);
    chk("word", 9'h0C3, rx_word);
    repeat (8) @(posedge clk);
    rd(ATF_OFS_STATUS, 32'h3);
    apb(1'b1, ATF_OFS_CTL2, 32'h1B);
    chk("irq masked", 2'h0, {tx_empty_irq, tx_complete_irq});
    cpu_irq_mask <= 2'h0;
    @(posedge clk);
    @(posedge clk);
    chk("irq", 2'h3, {tx_empty_irq, tx_complete_irq});
    apb(1'b1, ATF_OFS_CTL1, 32'h3);
    w9 <= 1'b1;
    rd(ATF_OFS_STATUS, 32'h3);
    apb(1'b1, ATF_OFS_DATA, 32'h5A);
    wait_rx(4);
    chk("word9", 9'h15A, rx_word);
    apb(1'b1, ATF_OFS_CTL1, 32'h4);
    apb(1'b1, ATF_OFS_DATA, 32'h07);
    wait_rx(5);
    chk("parity", 9'h107, rx_word);
    apb(1'b1, ATF_OFS_CTL2, 32'h1F);
    wait_rx(6);
    chk("break", 10'h000, {rx_stop, rx_word});
    apb(1'b1, ATF_OFS_CTL2, 32'h1B);
    repeat (100) @(posedge clk);
    chk("break tail", 1'b1, serial_out);
    rd(8'h20, 32'h0);
    chk("slave error", 1'b1, err);
    apb(1'b1, ATF_OFS_CTL2, 32'h0);
    repeat (80) @(posedge clk);
    chk("pin released", 1'b0, serial_out_en);
    end_sim();
  end
endmodule // testbench
